//--- pcg_defines.svh
// register map, field positions and reset values of the clock gating block
// How it works
// R1 - gating bit at 0 stops unit clock
// R2 - gating bit at 1 runs unit clock
// R3 - reset clears all four registers to zero
// R4 - software enables a unit before touching it
// R5 - software never gates a running unit
// R6 - timer register: bits 5,4,1,0 gate timers
// R7 - serial register: bits 4,1,0 gate serial
// R8 - third register: bit 5 rtc, bit 0 sync
// R9 - fourth register: bits 5..0 gate interrupts
// R10 - gates switch cleanly, no clock glitches
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_IDX_TIMER 12'hF74
`define PCG_IDX_SERIAL 12'hF75
`define PCG_IDX_RTCSYNC 12'hF76
`define PCG_IDX_EXTIRQ 12'hF77
`define PCG_ADDR_W 16
`define PCG_REG_RESET 8'h00

`define PCG_BIT_TPAIR_HI 5
`define PCG_BIT_TPAIR_LO 4
`define PCG_BIT_TA_SECOND 1
`define PCG_BIT_TA_FIRST 0
`define PCG_BIT_I2C 4
`define PCG_BIT_UART_SECOND 1
`define PCG_BIT_UART_FIRST 0
`define PCG_BIT_RTC 5
`define PCG_BIT_SYNC 0
`define PCG_IRQ_MSB 5

`endif

//--- pcg_pkg.sv
// types shared by the clock gating block
`default_nettype none
package pcg_pkg;

    typedef struct packed {
        logic [5:0] extIrq;
        logic syncSerial;
        logic realtimeClock;
        logic i2cUnit;
        logic asyncSerialSecond;
        logic asyncSerialFirst;
        logic timerPairHi;
        logic timerPairLo;
        logic typeATimerSecond;
        logic typeATimerFirst;
    } pcg_units_type;

    typedef struct packed {
        logic [15:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pcg_avl_req_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } pcg_bus_state_type;

endpackage : pcg_pkg
`default_nettype wire

//--- pcg_clock_gate.sv
// latch based glitch free clock gate cell
`timescale 1ns/1ns
`default_nettype none
module pcg_clock_gate (
    input wire logic clk,
    input wire logic enable,
    output logic gatedClk,
    output logic enLatched
);
    // latch is open only while clk is low, so the enable cannot
    // change during the high phase and cut a pulse short
    always_latch begin
        if (!clk) begin
            enLatched = enable; // [R10]
        end
    end

    assign gatedClk = clk & enLatched; // [R10]
endmodule : pcg_clock_gate
`default_nettype wire

//--- pcg_reg_slave.sv
// avalon-mm slave front end with one wait cycle per access
`timescale 1ns/1ns
`default_nettype none
module pcg_reg_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire pcg_pkg::pcg_avl_req_type req,
    input wire logic [31:0] rdValue,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic wrCommit
);
    import pcg_pkg::*;

    pcg_bus_state_type state_q;

    // the answer is registered: request seen at one edge, waitrequest
    // low after it, transfer done at the following edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= BUS_IDLE;
        end else begin
            case (state_q)
                BUS_IDLE: begin
                    if (req.read || req.write) begin
                        state_q <= BUS_ANSWER;
                    end
                end
                default: begin
                    state_q <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(state_q == BUS_IDLE && (req.read || req.write));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (state_q == BUS_IDLE && req.read) begin
            readdata <= rdValue;
        end
    end

    assign wrCommit = req.write && !waitrequest && req.byteenable[0];
endmodule : pcg_reg_slave
`default_nettype wire

//--- pcg_peripheral_clock_gating.sv
// per-peripheral clock gating registers and gate cells
`timescale 1ns/1ns
`default_nettype none
`include "pcg_defines.svh"
module pcg_peripheral_clock_gating (
    input wire logic clk,
    input wire logic rst_n,
    input wire pcg_pkg::pcg_avl_req_type avlReq,
    output logic [31:0] avlReaddata,
    output logic avlWaitrequest,
    output pcg_pkg::pcg_units_type unitClocks,
    output pcg_pkg::pcg_units_type unitOn_q
);
    import pcg_pkg::*;

    localparam int NUM_UNITS = $bits(pcg_units_type);

    logic [7:0] timerGates_q;
    logic [7:0] serialGates_q;
    logic [7:0] rtcSyncGates_q;
    logic [7:0] extIrqGates_q;
    logic wrCommit;
    logic [31:0] rdValue;
    logic [7:0] wrByte;
    pcg_units_type enVec;
    logic [NUM_UNITS-1:0] enFlat;
    logic [NUM_UNITS-1:0] clkFlat;
    logic [NUM_UNITS-1:0] latchFlat;

    // byte address of a register from its printed index
    function automatic logic [15:0] regAddr(input logic [11:0] idx);
        regAddr = {2'b00, idx, 2'b00};
    endfunction : regAddr

    function automatic logic isReg(input logic [15:0] a,
                                   input logic [11:0] idx);
        isReg = (a == regAddr(idx));
    endfunction : isReg

    // gating bits to unit enables
    function automatic pcg_units_type mapUnits(input logic [7:0] r0,
                                               input logic [7:0] r1,
                                               input logic [7:0] r2,
                                               input logic [7:0] r3);
        pcg_units_type u;
        u.typeATimerFirst = r0[`PCG_BIT_TA_FIRST]; // [R6]
        u.typeATimerSecond = r0[`PCG_BIT_TA_SECOND]; // [R6]
        u.timerPairLo = r0[`PCG_BIT_TPAIR_LO]; // [R6]
        u.timerPairHi = r0[`PCG_BIT_TPAIR_HI]; // [R6]
        u.asyncSerialFirst = r1[`PCG_BIT_UART_FIRST]; // [R7]
        u.asyncSerialSecond = r1[`PCG_BIT_UART_SECOND]; // [R7]
        u.i2cUnit = r1[`PCG_BIT_I2C]; // [R7]
        u.syncSerial = r2[`PCG_BIT_SYNC]; // [R8]
        u.realtimeClock = r2[`PCG_BIT_RTC]; // [R8]
        u.extIrq = r3[`PCG_IRQ_MSB:0]; // [R9]
        mapUnits = u;
    endfunction : mapUnits

    pcg_reg_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .req(avlReq),
        .rdValue(rdValue),
        .readdata(avlReaddata),
        .waitrequest(avlWaitrequest),
        .wrCommit(wrCommit)
    );

    assign wrByte = avlReq.writedata[7:0];

    // spare bits are plain storage and read back as written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timerGates_q <= `PCG_REG_RESET; // [R3]
        end else if (wrCommit && isReg(avlReq.address, `PCG_IDX_TIMER)) begin
            timerGates_q <= wrByte; // [R6]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serialGates_q <= `PCG_REG_RESET; // [R3]
        end else if (wrCommit &&
                     isReg(avlReq.address, `PCG_IDX_SERIAL)) begin
            serialGates_q <= wrByte; // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rtcSyncGates_q <= `PCG_REG_RESET; // [R3]
        end else if (wrCommit &&
                     isReg(avlReq.address, `PCG_IDX_RTCSYNC)) begin
            rtcSyncGates_q <= wrByte; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            extIrqGates_q <= `PCG_REG_RESET; // [R3]
        end else if (wrCommit &&
                     isReg(avlReq.address, `PCG_IDX_EXTIRQ)) begin
            extIrqGates_q <= wrByte; // [R9]
        end
    end

    // unmapped addresses read as zero and ignore writes
    always_comb begin
        rdValue = 32'h0000_0000;
        if (isReg(avlReq.address, `PCG_IDX_TIMER)) begin
            rdValue[7:0] = timerGates_q;
        end else if (isReg(avlReq.address, `PCG_IDX_SERIAL)) begin
            rdValue[7:0] = serialGates_q;
        end else if (isReg(avlReq.address, `PCG_IDX_RTCSYNC)) begin
            rdValue[7:0] = rtcSyncGates_q;
        end else if (isReg(avlReq.address, `PCG_IDX_EXTIRQ)) begin
            rdValue[7:0] = extIrqGates_q;
        end
    end

    assign enVec = mapUnits(timerGates_q, serialGates_q,
                            rtcSyncGates_q, extIrqGates_q);
    assign enFlat = enVec;

    // software must not drop a bit while its unit runs; the gate
    // still stops cleanly, but the unit may be left mid-operation
    for (genvar i = 0; i < NUM_UNITS; i++) begin : g_gate
        pcg_clock_gate u_gate (
            .clk(clk),
            .enable(enFlat[i]), // [R1] [R2] [R5]
            .gatedClk(clkFlat[i]),
            .enLatched(latchFlat[i])
        );
    end

    // gated clocks cannot come from a flop without adding skew
    assign unitClocks = clkFlat;

    // availability flags for the units, one cycle behind the registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unitOn_q <= '0; // [R3]
        end else begin
            unitOn_q <= enVec; // [R1] [R2]
        end
    end

    property p_reg_written(logic [11:0] idx);
        @(posedge clk) disable iff (!rst_n)
        wrCommit && isReg(avlReq.address, idx);
    endproperty : p_reg_written

    chk_reset_clears_all: assert property ( // [R3]
        @(posedge clk) !rst_n |=> (timerGates_q == 8'h00 &&
            serialGates_q == 8'h00 && rtcSyncGates_q == 8'h00 &&
            extIrqGates_q == 8'h00 && unitOn_q == '0))
        else $error("gating registers not cleared by reset");

    chk_gate_off_stops: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((NUM_UNITS'(unitOn_q) & ~$past(enFlat)) == '0))
        else $error("unit marked on while its gating bit is 0");

    chk_gate_on_runs: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((~NUM_UNITS'(unitOn_q) & $past(enFlat)) == '0))
        else $error("unit marked off while its gating bit is 1");

    chk_timer_bits_map: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        (wrCommit && isReg(avlReq.address, `PCG_IDX_TIMER)) |=> ##1
        ({unitOn_q.timerPairHi, unitOn_q.timerPairLo,
          unitOn_q.typeATimerSecond, unitOn_q.typeATimerFirst} ==
         {$past(wrByte[5], 2), $past(wrByte[4], 2),
          $past(wrByte[1], 2), $past(wrByte[0], 2)} &&
         timerGates_q == $past(wrByte, 2)))
        else $error("timer gating bits not mapped to timer units");

    chk_serial_bits_map: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        (wrCommit && isReg(avlReq.address, `PCG_IDX_SERIAL)) |=> ##1
        ({unitOn_q.i2cUnit, unitOn_q.asyncSerialSecond,
          unitOn_q.asyncSerialFirst} ==
         {$past(wrByte[4], 2), $past(wrByte[1], 2), $past(wrByte[0], 2)} &&
         serialGates_q == $past(wrByte, 2)))
        else $error("serial gating bits not mapped to serial units");

    chk_rtc_sync_map: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_n)
        (wrCommit && isReg(avlReq.address, `PCG_IDX_RTCSYNC)) |=> ##1
        ({unitOn_q.realtimeClock, unitOn_q.syncSerial} ==
         {$past(wrByte[5], 2), $past(wrByte[0], 2)} &&
         rtcSyncGates_q == $past(wrByte, 2)))
        else $error("third register bits not mapped to rtc and sync");

    chk_irq_bits_map: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_n)
        (wrCommit && isReg(avlReq.address, `PCG_IDX_EXTIRQ)) |=> ##1
        (unitOn_q.extIrq == $past(wrByte[5:0], 2) &&
         extIrqGates_q == $past(wrByte, 2)))
        else $error("interrupt gating bits not mapped");

    chk_clean_gate_latch: assert property ( // [R10]
        @(posedge clk) disable iff (!rst_n)
        latchFlat == enFlat)
        else $error("gate latch differs from enable at clock rise");

    chk_bus_answer_time: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((avlReq.read || avlReq.write) && avlWaitrequest)
        |-> ##[0:2] !avlWaitrequest)
        else $error("bus access not answered within two cycles");

    chk_bus_reset_idle: assert property ( // [R3]
        @(posedge clk) !rst_n |=> (avlWaitrequest &&
            avlReaddata == 32'h0000_0000))
        else $error("bus outputs not idle after reset");

    chk_wait_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !avlWaitrequest |=> avlWaitrequest)
        else $error("waitrequest low for more than one cycle");

    chk_idle_bus_waits: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(avlReq.read || avlReq.write) |=> avlWaitrequest)
        else $error("waitrequest low with no request");

    chk_upper_read_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        avlReaddata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    chk_read_data_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        !avlReq.read |=> $stable(avlReaddata))
        else $error("read data changed without a read");

    // a write without the low byte lane carries no gating byte
    chk_low_lane_off: assert property ( // [R6] [R7] [R8] [R9]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.write && !avlWaitrequest && !avlReq.byteenable[0]) |=>
        ($stable(timerGates_q) && $stable(serialGates_q) &&
         $stable(rtcSyncGates_q) && $stable(extIrqGates_q)))
        else $error("write without low byte lane changed a register");

    chk_unmapped_ignored: assert property ( // [R6] [R7] [R8] [R9]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.write && !avlWaitrequest &&
         !isReg(avlReq.address, `PCG_IDX_TIMER) &&
         !isReg(avlReq.address, `PCG_IDX_SERIAL) &&
         !isReg(avlReq.address, `PCG_IDX_RTCSYNC) &&
         !isReg(avlReq.address, `PCG_IDX_EXTIRQ)) |=>
        ($stable(timerGates_q) && $stable(serialGates_q) &&
         $stable(rtcSyncGates_q) && $stable(extIrqGates_q)))
        else $error("write to an unmapped place changed a register");

    // read data is loaded one edge early; no write can land between
    chk_timer_read_back: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.read && !avlWaitrequest &&
         isReg(avlReq.address, `PCG_IDX_TIMER)) |->
        avlReaddata == {24'h000000, timerGates_q})
        else $error("timer gating register read back wrong");

    chk_serial_read_back: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.read && !avlWaitrequest &&
         isReg(avlReq.address, `PCG_IDX_SERIAL)) |->
        avlReaddata == {24'h000000, serialGates_q})
        else $error("serial gating register read back wrong");

    chk_rtc_read_back: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.read && !avlWaitrequest &&
         isReg(avlReq.address, `PCG_IDX_RTCSYNC)) |->
        avlReaddata == {24'h000000, rtcSyncGates_q})
        else $error("third gating register read back wrong");

    chk_irq_read_back: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_n)
        (avlReq.read && !avlWaitrequest &&
         isReg(avlReq.address, `PCG_IDX_EXTIRQ)) |->
        avlReaddata == {24'h000000, extIrqGates_q})
        else $error("interrupt gating register read back wrong");

    // on the falling edge a gated clock shows its latched enable
    chk_clock_matches_on: assert property ( // [R1] [R2]
        @(negedge clk) disable iff (!rst_n)
        clkFlat == NUM_UNITS'(unitOn_q))
        else $error("gated clock disagrees with unit flag");

    chk_gated_low_phase: assert property ( // [R10]
        @(posedge clk) disable iff (!rst_n)
        clkFlat == '0)
        else $error("gated clock high while clock low");

    cov_timer_write: cover property (p_reg_written(`PCG_IDX_TIMER));
    cov_irq_write: cover property (p_reg_written(`PCG_IDX_EXTIRQ));
    cov_unit_on_off: cover property (
        @(posedge clk) disable iff (!rst_n)
        unitOn_q.asyncSerialFirst ##1 !unitOn_q.asyncSerialFirst);
    cov_read_back: cover property (
        @(posedge clk) disable iff (!rst_n)
        avlReq.read && !avlWaitrequest && avlReaddata[7:0] != 8'h00);
    cov_lane_off_write: cover property (
        @(posedge clk) disable iff (!rst_n)
        avlReq.write && !avlWaitrequest && !avlReq.byteenable[0]);
endmodule : pcg_peripheral_clock_gating
`default_nettype wire

//--- pcg_unit_model.sv
// behavioural model of the gated units: counts clock pulses per unit
`timescale 1ns/1ns
`default_nettype none
module pcg_unit_model (
    input wire pcg_pkg::pcg_units_type unitClocks,
    output wire logic [14:0][15:0] pulseCount
);
    import pcg_pkg::*;
    logic [14:0] clkVec;
    assign clkVec = unitClocks;
    // a unit only advances on the edges its gate lets through
    for (genvar i = 0; i < 15; i++) begin : g_unit
        logic [15:0] cnt = 16'h0000;
        always @(posedge clkVec[i]) begin
            cnt <= cnt + 16'h0001;
        end
        assign pulseCount[i] = cnt;
    end
endmodule : pcg_unit_model
`default_nettype wire

//--- pcg_peripheral_clock_gating_tb_top.sv
// self-checking testbench of the clock gating block
`timescale 1ns/1ns
`default_nettype none
module pcg_peripheral_clock_gating_tb_top;
    import pcg_pkg::*;
    localparam logic [15:0] baseAddr = 16'h3DD0;
    logic clk;
    logic rst_n;
    pcg_avl_req_type avlReq;
    logic [31:0] avlReaddata;
    logic avlWaitrequest;
    pcg_units_type unitClocks;
    pcg_units_type unitOn_q;
    logic [14:0][15:0] pulseCount;
    logic [7:0] regs [4];
    logic [31:0] expQ [$];
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] expRd;

    pcg_peripheral_clock_gating dut (.clk(clk), .rst_n(rst_n),
        .avlReq(avlReq), .avlReaddata(avlReaddata),
        .avlWaitrequest(avlWaitrequest), .unitClocks(unitClocks),
        .unitOn_q(unitOn_q));
    pcg_unit_model model (.unitClocks(unitClocks), .pulseCount(pulseCount));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    function automatic pcg_units_type expUnits();
        return {regs[3][5:0], regs[2][0], regs[2][5], regs[1][4], regs[1][1],
            regs[1][0], regs[0][5], regs[0][4], regs[0][1], regs[0][0]};
    endfunction : expUnits

    // request held until waitrequest is seen low, then released
    task automatic busOp(input logic wr, input logic [15:0] a,
            input logic [31:0] d, input logic [3:0] be);
        int n;
        logic hit;
        n = 0;
        hit = (a[15:4] == 12'h3DD);
        if (!wr) begin
            expQ.push_back(hit ? {24'h000000, regs[a[3:2]]} : 32'h00000000);
        end else if (hit && be[0]) begin
            regs[a[3:2]] = d[7:0];
        end
        avlReq <= '{address: a, read: !wr, write: wr, writedata: d,
            byteenable: be};
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                n_errors++;
                report_and_stop();
            end
        end while (avlWaitrequest !== 1'b0);
        avlReq.read <= 1'b0;
        avlReq.write <= 1'b0;
        @(posedge clk);
    endtask : busOp

    task automatic doReset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        regs = '{default: 8'h00};
    endtask : doReset

    task automatic readAll();
        for (int k = 0; k < 4; k++) begin
            busOp(1'b0, baseAddr + 16'(4 * k), 32'h00000000, 4'hF);
        end
    endtask : readAll

    // read results are taken off the queue when they appear
    always @(posedge clk) begin
        if (rst_n === 1'b1 && avlReq.read === 1'b1 &&
                avlWaitrequest === 1'b0) begin
            if (expQ.size() == 0) begin
                n_errors++;
            end else begin
                expRd = expQ.pop_front();
                check(avlReaddata, expRd);
            end
        end
    end

    initial begin
        logic [31:0] d;
        logic [15:0] a;
        logic [14:0][15:0] snap;
        pcg_units_type on;
        avlReq = '0;
        rst_n = 1'b0;
        regs = '{default: 8'h00};
        void'($urandom(32'hA62B));
        doReset();
        readAll();
        check(32'(unitOn_q), 32'h00000000);
        // walking one through every bit, random upper bits ignored
        for (int k = 0; k < 4; k++) begin
            a = baseAddr + 16'(4 * k);
            for (int b = 0; b < 8; b++) begin
                d = $urandom();
                d[7:0] = 8'h01 << b;
                busOp(1'b1, a, d, 4'hF);
                busOp(1'b0, a, 32'h00000000, 4'hF);
                check(32'(unitOn_q), 32'(expUnits()));
            end
            busOp(1'b1, a, 32'h00000000, 4'hF);
        end
        // random data and byte enables, back to back
        repeat (24) begin
            a = baseAddr + 16'(4 * ($urandom() % 4));
            busOp(1'b1, a, $urandom(), 4'($urandom()));
            busOp(1'b0, a, 32'h00000000, 4'hF);
            check(32'(unitOn_q), 32'(expUnits()));
        end
        // unmapped places answer zero and change nothing
        busOp(1'b1, 16'h3DE0, 32'hFFFFFFFF, 4'hF);
        busOp(1'b0, 16'h3DE0, 32'h00000000, 4'hF);
        busOp(1'b1, 16'h3DCC, 32'hFFFFFFFF, 4'hF);
        readAll();
        // gates only change outside the pulse windows
        repeat (4) begin
            for (int k = 0; k < 4; k++) begin
                busOp(1'b1, baseAddr + 16'(4 * k), $urandom(), 4'hF);
            end
            on = expUnits();
            @(negedge clk);
            snap = pulseCount;
            repeat (10) @(negedge clk);
            for (int i = 0; i < 15; i++) begin
                d = {16'h0000, pulseCount[i] - snap[i]};
                check(d, on[i] ? 32'hA : 32'h0);
            end
            @(posedge clk);
        end
        // second reset in mid-run closes every gate again
        doReset();
        readAll();
        check(32'(unitOn_q), 32'h00000000);
        report_and_stop();
    end
endmodule : pcg_peripheral_clock_gating_tb_top
`default_nettype wire
